// File: testbench/ism_far_model.sv
/*
 far-side model: puts pin levels and fault levels onto the block inputs.
 assumes the bench hands next values just after a rising edge.
*/
`timescale 1ns/10ps
module ism_far_model (
	// clock
	input  wire logic                aclk,
	// next levels
	input  wire ism_pkg::ism_pins_t  pins_nxt,
	input  wire ism_pkg::ism_fault_t faults_nxt,
	// levels toward the block
	output      ism_pkg::ism_pins_t  pins,
	output      ism_pkg::ism_fault_t faults
);
	import ism_pkg::*;
	// registered so levels move only after an edge, as synchronised sources do
	always_ff @(posedge aclk) begin
		pins <= pins_nxt;
		faults <= faults_nxt;
	end
endmodule

// File: testbench/test_irq_source_mux_break_lock.sv
/*
 self-checking bench: register access, line selection, break locks, locked settings.
 assumes ism_far_model drives pins and faults; clock enable held high except during the line hold check.
*/
`timescale 1ns/10ps
`include "ism_defines.svh"
module test_irq_source_mux_break_lock;
	import ism_pkg::*;
	logic          aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic [11:0]   awaddr = 12'h000, araddr = 12'h000;
	logic [31:0]   wdata = 32'h0, rdata, seed = 32'h000087c1;
	logic [3:0]    wstrb = 4'h0;
	logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic          awready, wready, bvalid, arready, rvalid, brk;
	logic [1:0]    bresp, rresp;
	logic [15:8]   line;
	ism_vdet_cfg_t vdet;
	ism_pins_t     pn = '0, pins;
	ism_fault_t    fl = '0, faults;
	int            err_count = 0, num_checks = 0;
	always #10 aclk = ~aclk;
	ism_far_model ism_far_model_i (.aclk(aclk), .pins_nxt(pn), .faults_nxt(fl), .pins(pins), .faults(faults));
	ism_top ism_top_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins(pins), .faults(faults),
		.line_irq_r(line), .timer_break_r(brk), .vdet_cfg_r(vdet));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] exp_l(logic [31:0] s, ism_pins_t p);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) begin
			case (s[4*i+:3])
				3'h0: r[i] = p.port_a[8+i];
				3'h1: r[i] = p.port_b[8+i];
				3'h2: r[i] = p.port_c[8+i];
				3'h3: r[i] = p.port_d[8+i];
				3'h4: r[i] = p.port_e[8+i];
				default: r[i] = 1'b0;
			endcase
		end
		return r;
	endfunction
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", 32'(er), 32'(bresp));
		@(posedge aclk);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk("rdata", e, rdata);
		chk("rresp", 32'(er), 32'(rresp));
		@(posedge aclk);
	endtask
	// one edge into the far model, one into the block, one to sample
	task settle();
		repeat (3) @(posedge aclk);
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#400000;
		err_count++;
		stop_test();
	end
	initial begin
		logic [31:0] s;
		logic [2:0]  m;
		logic [7:0]  hold_e;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		pn <= 80'({xs(), xs(), xs()});
		settle();
		chk("line", 32'(pn.port_a[15:8]), 32'(line));
		rd(`ISM_OFF_SEL_8_11, 32'h0, `ISM_RESP_OKAY);
		rd(`ISM_OFF_SEL_12_15, 32'h0, `ISM_RESP_OKAY);
		rd(`ISM_OFF_LOCK_CFG, 32'h0, `ISM_RESP_OKAY);
		// every code on every line, reserved codes included, bit 3 random
		for (int k = 0; k < 8; k++) begin
			for (int i = 0; i < 8; i++) s[4*i+:4] = {1'(xs()), 3'((k + i) % 8)};
			wr(`ISM_OFF_SEL_8_11, {16'h0, s[15:0]}, 4'hf, `ISM_RESP_OKAY);
			wr(`ISM_OFF_SEL_12_15, {16'h0, s[31:16]}, 4'hf, `ISM_RESP_OKAY);
			rd(`ISM_OFF_SEL_8_11, {16'h0, s[15:0]}, `ISM_RESP_OKAY);
			rd(`ISM_OFF_SEL_12_15, {16'h0, s[31:16]}, `ISM_RESP_OKAY);
			pn <= 80'({xs(), xs(), xs()});
			settle();
			chk("line", 32'(exp_l(s, pn)), 32'(line));
		end
		fl <= 3'(xs());
		settle();
		chk("break", 32'h0, 32'(brk));
		wr(`ISM_OFF_PWR_CTL, 32'h0000000b, 4'hf, `ISM_RESP_OKAY);
		settle();
		chk("vdet", 32'h0000000d, 32'(vdet));
		m = 3'h0;
		for (int b = 0; b < 3; b++) begin
			m[b] = 1'b1;
			wr(`ISM_OFF_LOCK_CFG, 32'h1 << b, 4'hf, `ISM_RESP_OKAY);
			wr(`ISM_OFF_LOCK_CFG, 32'h0, 4'hf, `ISM_RESP_OKAY);
			rd(`ISM_OFF_LOCK_CFG, 32'(m), `ISM_RESP_OKAY);
			repeat (4) begin
				fl <= 3'(xs());
				settle();
				chk("break", 32'(|(fl & m)), 32'(brk));
			end
		end
		wr(`ISM_OFF_PWR_CTL, 32'h00000004, 4'hf, `ISM_RESP_OKAY);
		settle();
		chk("vdet", 32'h0000000d, 32'(vdet));
		wr(`ISM_OFF_SEL_8_11, 32'h0, 4'h3, `ISM_RESP_SLVERR);
		rd(`ISM_OFF_SEL_8_11, {16'h0, s[15:0]}, `ISM_RESP_OKAY);
		rd(12'h024, 32'h0, `ISM_RESP_SLVERR);
		// clock enable low: lines must hold while pins move
		hold_e = exp_l(s, pn);
		ce <= 1'b0;
		pn <= 80'({xs(), xs(), xs()});
		settle();
		chk("line_frozen", 32'(hold_e), 32'(line));
		ce <= 1'b1;
		settle();
		chk("line", 32'(exp_l(s, pn)), 32'(line));
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`ISM_OFF_LOCK_CFG, 32'h0, `ISM_RESP_OKAY);
		settle();
		chk("break", 32'h0, 32'(brk));
		stop_test();
	end
endmodule

// File: verilog/ism_defines.svh
/*
 interrupt source mux / break lock constants: offsets, field layout, reset values.
 assumes inclusion by bare name from the modules and the bench.
*/
`ifndef ISM_DEFINES_SVH
`define ISM_DEFINES_SVH
`define ISM_OFF_SEL_8_11   12'h010
`define ISM_OFF_SEL_12_15  12'h014
`define ISM_OFF_LOCK_CFG   12'h018
`define ISM_OFF_PWR_CTL    12'h020
`define ISM_SEL_RESET      16'h0000
`define ISM_LOCK_RESET     3'h0
`define ISM_PWR_RESET      4'h0
`define ISM_BIT_CORE_LOCK  0
`define ISM_BIT_ECC_LOCK   1
`define ISM_BIT_VDET_LOCK  2
`define ISM_BIT_VDET_EN    0
`define ISM_PORT_A         3'h0
`define ISM_PORT_B         3'h1
`define ISM_PORT_C         3'h2
`define ISM_PORT_D         3'h3
`define ISM_PORT_E         3'h4
`define ISM_RESP_OKAY      2'h0
`define ISM_RESP_SLVERR    2'h2
`endif

// File: verilog/ism_line_mux.sv
/*
 one interrupt line: decodes the low 3 bits of a 4-bit selector and registers the chosen pin level.
 assumes pins synchronous to aclk.
*/
`timescale 1ns/10ps
`include "ism_defines.svh"
module ism_line_mux (
	// clock
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ce,
	// select and pins
	input  wire logic [3:0] sel,
	input  wire logic [4:0] pins,
	// line
	output      logic       line_r
);
	logic line_nxt;
	always_comb begin
		unique case (sel[2:0])
			`ISM_PORT_A: line_nxt = pins[0];
			`ISM_PORT_B: line_nxt = pins[1];
			`ISM_PORT_C: line_nxt = pins[2];
			`ISM_PORT_D: line_nxt = pins[3];
			`ISM_PORT_E: line_nxt = pins[4];
			default:     line_nxt = 1'b0; // reserved codes select nothing
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			line_r <= 1'b0;
		else if (ce)
			line_r <= line_nxt;
	end
endmodule

// File: verilog/ism_pkg.sv
/*
 types for the interrupt source mux / break lock block.
 assumes ism_defines.svh provides the numbers.
*/
package ism_pkg;
	typedef struct packed {
		logic [15:0] port_a;
		logic [15:0] port_b;
		logic [15:0] port_c;
		logic [15:0] port_d;
		logic [15:0] port_e;
	} ism_pins_t;
	typedef struct packed {
		logic vdet_irq;
		logic ecc_err;
		logic core_stall;
	} ism_fault_t;
	typedef struct packed {
		logic       enable;
		logic [2:0] threshold;
	} ism_vdet_cfg_t;
	typedef enum logic [1:0] {ISM_W_IDLE, ISM_W_RESP} ism_wstate_t;
endpackage

// File: verilog/ism_top.sv
/*
 interrupt source select for lines 8..15, fault-to-break lock register, and locked
 voltage detector settings, behind an AXI4-Lite slave.
 assumes one clock, synchronous active-low reset, pins synchronous to aclk.
*/
`timescale 1ns/10ps
`include "ism_defines.svh"
module ism_top (
	// clock and reset
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic                ce,
	// axi4-lite write address
	input  wire logic [11:0]         s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output      logic                s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output      logic                s_axi_wready,
	// axi4-lite write response
	output      logic [1:0]          s_axi_bresp,
	output      logic                s_axi_bvalid,
	input  wire logic                s_axi_bready,
	// axi4-lite read address
	input  wire logic [11:0]         s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output      logic                s_axi_arready,
	// axi4-lite read data
	output      logic [31:0]         s_axi_rdata,
	output      logic [1:0]          s_axi_rresp,
	output      logic                s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// port pins and fault sources
	input  wire ism_pkg::ism_pins_t  pins,
	input  wire ism_pkg::ism_fault_t faults,
	// outputs
	output      logic [15:8]         line_irq_r,
	output      logic                timer_break_r,
	output      ism_pkg::ism_vdet_cfg_t vdet_cfg_r
);
	import ism_pkg::*;

	logic [15:0] sel_lo_r;
	logic [15:0] sel_hi_r;
	logic [2:0]  lock_r;
	logic [11:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        aw_have_r;
	logic        w_have_r;
	logic        wr_go;
	logic        wr_full;
	logic        rd_hit;
	logic [31:0] rd_nxt;

	// write channel capture: address and data in either order
	assign wr_go   = aw_have_r && w_have_r && !s_axi_bvalid;
	assign wr_full = (wstrb_r == 4'hf);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r     <= 1'b0;
			w_have_r      <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			awaddr_r      <= 12'h000;
			wdata_r       <= 32'h00000000;
			wstrb_r       <= 4'h0;
		end else if (ce) begin
			s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end else if (wr_go)
				aw_have_r <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end else if (wr_go)
				w_have_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `ISM_RESP_OKAY;
		end else if (ce) begin
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_full && (awaddr_r == `ISM_OFF_SEL_8_11 || awaddr_r == `ISM_OFF_SEL_12_15 ||
					awaddr_r == `ISM_OFF_LOCK_CFG || awaddr_r == `ISM_OFF_PWR_CTL)) ? `ISM_RESP_OKAY : `ISM_RESP_SLVERR;
			end else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// selection registers; upper reserved half is not stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_lo_r <= `ISM_SEL_RESET;
			sel_hi_r <= `ISM_SEL_RESET;
		end else if (ce && wr_go && wr_full) begin
			if (awaddr_r == `ISM_OFF_SEL_8_11)
				sel_lo_r <= wdata_r[15:0];
			if (awaddr_r == `ISM_OFF_SEL_12_15)
				sel_hi_r <= wdata_r[15:0];
		end
	end

	// lock bits only ever set; reset is the sole way back
	always_ff @(posedge aclk) begin
		if (!aresetn)
			lock_r <= `ISM_LOCK_RESET;
		else if (ce && wr_go && wr_full && awaddr_r == `ISM_OFF_LOCK_CFG)
			lock_r <= lock_r | wdata_r[2:0];
	end

	// detector settings frozen while its lock is held
	always_ff @(posedge aclk) begin
		if (!aresetn)
			vdet_cfg_r <= `ISM_PWR_RESET;
		else if (ce && wr_go && wr_full && awaddr_r == `ISM_OFF_PWR_CTL && !lock_r[`ISM_BIT_VDET_LOCK])
			vdet_cfg_r <= {wdata_r[`ISM_BIT_VDET_EN], wdata_r[3:1]};
	end

	// read channel
	always_comb begin
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			`ISM_OFF_SEL_8_11:  rd_nxt = {16'h0000, sel_lo_r};
			`ISM_OFF_SEL_12_15: rd_nxt = {16'h0000, sel_hi_r};
			`ISM_OFF_LOCK_CFG:  rd_nxt = {29'h00000000, lock_r};
			`ISM_OFF_PWR_CTL:   rd_nxt = {28'h0000000, vdet_cfg_r.threshold, vdet_cfg_r.enable};
			default: begin
				rd_nxt = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `ISM_RESP_OKAY;
		end else if (ce) begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_nxt;
				s_axi_rresp  <= rd_hit ? `ISM_RESP_OKAY : `ISM_RESP_SLVERR;
			end else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// per-line muxes
	genvar gi;
	generate
		for (gi = 8; gi < 16; gi++) begin : g_line
			logic [3:0] sel_w;
			assign sel_w = (gi < 12) ? sel_lo_r[(gi-8)*4 +: 4] : sel_hi_r[(gi-12)*4 +: 4];
			ism_line_mux u_mux (
				.aclk    (aclk),
				.aresetn (aresetn),
				.ce      (ce),
				.sel     (sel_w),
				.pins    ({pins.port_e[gi], pins.port_d[gi], pins.port_c[gi], pins.port_b[gi], pins.port_a[gi]}),
				.line_r  (line_irq_r[gi])
			);
		end
	endgenerate

	// shared break request to the four advanced timers
	always_ff @(posedge aclk) begin
		if (!aresetn)
			timer_break_r <= 1'b0;
		else if (ce)
			timer_break_r <= (lock_r[`ISM_BIT_VDET_LOCK] && faults.vdet_irq) ||
				(lock_r[`ISM_BIT_ECC_LOCK] && faults.ecc_err) ||
				(lock_r[`ISM_BIT_CORE_LOCK] && faults.core_stall);
	end

	// checks
	// every bit, not just bit 0: a set lock may never drop while out of reset
	AST_LOCK_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
		1'b1 |-> ((lock_r & $past(lock_r)) == $past(lock_r))) else $error("lock bit cleared without reset");
	AST_LOCK_ONLY_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
		(lock_r != $past(lock_r)) |-> $past(wr_go && awaddr_r == `ISM_OFF_LOCK_CFG)) else $error("lock set by non-write");
	AST_VDET_BREAK: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && faults.vdet_irq && lock_r[`ISM_BIT_VDET_LOCK] |=> timer_break_r) else $error("detector break missing");
	AST_BREAK_BLOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && lock_r == 3'h0 |=> !timer_break_r) else $error("break without lock");
	AST_ECC_BREAK: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && faults.ecc_err && lock_r[`ISM_BIT_ECC_LOCK] |=> timer_break_r) else $error("ecc break missing");
	AST_STALL_BREAK: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && faults.core_stall && lock_r[`ISM_BIT_CORE_LOCK] |=> timer_break_r) else $error("stall break missing");
	AST_VDET_FROZEN: assert property (@(posedge aclk) disable iff (!aresetn)
		lock_r[`ISM_BIT_VDET_LOCK] |=> $stable(vdet_cfg_r)) else $error("detector settings changed under lock");
	AST_LINE8_A: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && sel_lo_r[2:0] == `ISM_PORT_A |=> line_irq_r[8] == $past(pins.port_a[8])) else $error("line 8 not port A");
	AST_LINE15_E: assert property (@(posedge aclk) disable iff (!aresetn)
		ce && sel_hi_r[14:12] == `ISM_PORT_E |=> line_irq_r[15] == $past(pins.port_e[15])) else $error("line 15 not port E");
	AST_PARTIAL_IGNORED: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_go && !wr_full |=> $stable(sel_lo_r) && $stable(sel_hi_r)) else $error("partial write took effect");
endmodule
